// file: core/msr_pkg.sv
// Constants and types shared by the monitor SPI frame logic
package msr_pkg;

  // Clock and timing
  localparam int CLK_NS      = 100;
  localparam int TIMEOUT_US  = 2000;
  localparam int TIMEOUT_CYC = (TIMEOUT_US * 1000) / CLK_NS;
  localparam int DRH_NS      = 500;
  localparam int DRH_CYC     = (DRH_NS + CLK_NS - 1) / CLK_NS;

  // Command words and opcodes
  localparam logic [2:0]  OP_RD      = 3'h5;
  localparam logic [2:0]  OP_WR      = 3'h3;
  localparam logic [15:0] CMD_NOP    = 16'h0000;
  localparam logic [15:0] CMD_RST    = 16'h0011;
  localparam logic [15:0] CMD_LOCK   = 16'h0555;
  localparam logic [15:0] CMD_UNLOCK = 16'h0655;

  // Command response codes
  localparam logic [3:0] RESP_NOP    = 4'h0;
  localparam logic [3:0] RESP_RST    = 4'h1;
  localparam logic [3:0] RESP_LOCK   = 4'h2;
  localparam logic [3:0] RESP_UNLOCK = 4'h3;
  localparam logic [3:0] RESP_RD     = 4'h4;
  localparam logic [3:0] RESP_WR     = 4'h5;
  localparam logic [3:0] RESP_ERR    = 4'hF;

  // Word lengths and frame layout
  localparam logic [5:0] WLEN_S     = 6'h18;
  localparam logic [5:0] WLEN_L     = 6'h20;
  localparam logic [5:0] IDX_CMD    = 6'h00;
  localparam logic [5:0] IDX_CRC    = 6'h01;
  localparam logic [5:0] IDX_FIRST  = 6'h01;
  localparam logic [5:0] IDX_SECOND = 6'h02;
  localparam logic [5:0] IDX_DATA   = 6'h02;
  localparam logic [5:0] NORM_WORDS = 6'h04;
  localparam logic [5:0] WR_EXTRA   = 6'h04;
  localparam logic [5:0] RD_EXTRA   = 6'h02;
  localparam logic [7:0] AUX_BASE   = 8'h10;

  typedef struct packed {
    logic [2:0] op;
    logic [7:0] addr;
    logic [4:0] num;
  } msr_cmd_t;

  typedef struct packed {
    logic [23:0] value;
    logic [1:0]  count;
  } msr_res_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FRAME = 2'b01,
    ST_DEAD  = 2'b10
  } msr_state_t;

endpackage

// file: core/msr_spi_target.sv
// Monitor SPI target: frame logic, readout, clock count and timeout checks
`timescale 1ns/1ns
module msr_spi_target #(
  parameter int TIMEOUT_CYC = msr_pkg::TIMEOUT_CYC
) (
  input  logic        mclk,
  input  logic        rstn,
  input  logic        chip_select_low,
  input  logic        sclk,
  input  logic        sdi,
  output logic        sdo,
  input  logic        word_length_sel,
  input  logic        clock_counter_en,
  input  logic        select_timeout_en,
  input  logic        data_ready_source_select,
  input  logic        adc_first_done,
  input  logic [23:0] adc_first_value,
  input  logic        adc_second_done,
  input  logic [23:0] adc_second_value,
  output logic [7:0]  reg_rd_addr,
  input  logic [15:0] reg_rd_value,
  input  logic        reg_rd_valid,
  input  logic        conversion_start_bit,
  output logic        cmd_exec,
  output logic [15:0] cmd_word,
  output logic        wr_data_strobe,
  output logic [15:0] wr_data,
  output logic        data_ready_pin,
  output logic        clock_count_fault_flag,
  output logic        select_timeout_flag
);

  logic [2:0]           sync_s;
  logic                 sclk_s;
  logic                 cs_s;
  logic                 sdi_s;
  logic                 sclk_q;
  msr_pkg::msr_state_t  state_reg;
  logic                 frame_start;
  logic                 frame_end;
  logic                 fall_ev;
  logic                 rise_ev;
  logic                 word_end;
  logic [5:0]           wlen;
  logic [5:0]           bit_cnt_reg;
  logic [5:0]           word_idx_reg;
  logic [5:0]           nxt_idx;
  logic [31:0]          tx_reg;
  logic [31:0]          rx_reg;
  logic [31:0]          rx_next;
  logic [31:0]          tx_word;
  logic [15:0]          rx_half;
  logic [23:0]          status_word;
  msr_pkg::msr_cmd_t    cmd_reg;
  logic                 is_rd;
  logic                 is_wr;
  logic                 is_rst;
  logic [5:0]           wr_last;
  logic [5:0]           sdi_words;
  logic [5:0]           sdo_words;
  logic [5:0]           frame_words;
  logic [3:0]           resp_reg;
  logic [3:0]           resp_pend;
  logic                 rd_active_reg;
  logic                 rd_pend_reg;
  logic [5:0]           rd_num_reg;
  logic [11:0]          pcnt_reg;
  logic [11:0]          exp_reg;
  logic [23:0]          to_cnt_reg;
  logic                 to_expire;
  logic                 to_seen_reg;
  msr_pkg::msr_res_t    res_a_reg;
  msr_pkg::msr_res_t    res_b_reg;
  msr_pkg::msr_res_t    frm_a_reg;
  msr_pkg::msr_res_t    frm_b_reg;
  logic                 sel_done;
  logic                 new_flag_reg;
  logic                 second_read;
  logic [7:0]           hold_reg;

  msr_sync3 u_sync (
    .mclk     (mclk),
    .rstn     (rstn),
    .async_in ({sclk, chip_select_low, sdi}),
    .sync_out (sync_s)
  );

  assign sclk_s = sync_s[2];
  assign cs_s   = sync_s[1];
  assign sdi_s  = sync_s[0];

  // Frame boundaries and clock edges seen on the system clock
  assign frame_start = (state_reg == msr_pkg::ST_IDLE) && !cs_s;
  assign frame_end   = (state_reg != msr_pkg::ST_IDLE) && cs_s;
  assign fall_ev     = (state_reg == msr_pkg::ST_FRAME) && !cs_s && sclk_q && !sclk_s;
  assign rise_ev     = (state_reg == msr_pkg::ST_FRAME) && !cs_s && !sclk_q && sclk_s;

  assign wlen     = word_length_sel ? msr_pkg::WLEN_L : msr_pkg::WLEN_S;
  assign word_end = fall_ev && (bit_cnt_reg == wlen - 6'h01);
  assign rx_next  = {rx_reg[30:0], sdi_s};
  assign rx_half  = word_length_sel ? rx_next[31:16] : rx_next[23:8];
  assign nxt_idx  = frame_start ? msr_pkg::IDX_CMD : word_idx_reg + 6'h01;

  assign is_rd   = cmd_reg.op == msr_pkg::OP_RD;
  assign is_wr   = cmd_reg.op == msr_pkg::OP_WR;
  assign is_rst  = cmd_reg == msr_pkg::CMD_RST;
  assign wr_last = {3'h0, cmd_reg.num[2:0]} + 6'h03;

  assign sdi_words   = is_wr ? {3'h0, cmd_reg.num[2:0]} + msr_pkg::WR_EXTRA : msr_pkg::NORM_WORDS;
  assign sdo_words   = rd_active_reg ? rd_num_reg + msr_pkg::RD_EXTRA : msr_pkg::NORM_WORDS;
  assign frame_words = (sdi_words > sdo_words) ? sdi_words : sdo_words;

  assign status_word = {clock_count_fault_flag, select_timeout_flag, resp_reg,
                        res_a_reg.count, res_b_reg.count, 14'h0000};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= msr_pkg::ST_IDLE;
      sclk_q    <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
      case (state_reg)
        msr_pkg::ST_IDLE: begin
          if (!cs_s) begin
            state_reg <= msr_pkg::ST_FRAME;
          end
        end
        msr_pkg::ST_FRAME: begin
          if (cs_s) begin
            state_reg <= msr_pkg::ST_IDLE;
          end else if (to_expire) begin
            state_reg <= msr_pkg::ST_DEAD;
          end
        end
        msr_pkg::ST_DEAD: begin
          if (cs_s) begin
            state_reg <= msr_pkg::ST_IDLE;
          end
        end
        default: state_reg <= msr_pkg::ST_IDLE;
      endcase
    end
  end

  // Next word to shift out on SDO
  always_comb begin
    tx_word = 32'h00000000;
    if (nxt_idx == msr_pkg::IDX_CMD) begin
      tx_word = {status_word, 8'h00};
    end else if (rd_active_reg) begin
      // value then address, zero if invalid
      if ((nxt_idx <= rd_num_reg) && reg_rd_valid) begin
        tx_word = {reg_rd_value, reg_rd_addr, 8'h00};
      end
    end else if (nxt_idx == msr_pkg::IDX_FIRST) begin
      tx_word = {frm_a_reg.value, 8'h00};
    end else if (nxt_idx == msr_pkg::IDX_SECOND) begin
      tx_word = {frm_b_reg.value, 8'h00};
    end
  end

  // Bit and word counters with the shift registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_reg  <= 6'h00;
      word_idx_reg <= 6'h00;
      tx_reg       <= 32'h00000000;
      rx_reg       <= 32'h00000000;
      sdo          <= 1'b0;
    end else if (frame_start) begin
      bit_cnt_reg  <= 6'h00;
      word_idx_reg <= 6'h00;
      tx_reg       <= tx_word;
    end else if (fall_ev) begin
      rx_reg <= rx_next;
      if (word_end) begin
        bit_cnt_reg  <= 6'h00;
        word_idx_reg <= word_idx_reg + 6'h01;
        tx_reg       <= tx_word;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
    end else if (rise_ev) begin
      sdo    <= tx_reg[31];
      tx_reg <= {tx_reg[30:0], 1'b0};
    end
  end

  // Command handling and responses
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_reg        <= msr_pkg::CMD_NOP;
      cmd_exec       <= 1'b0;
      cmd_word       <= 16'h0000;
      wr_data_strobe <= 1'b0;
      wr_data        <= 16'h0000;
      resp_reg       <= msr_pkg::RESP_NOP;
      resp_pend      <= msr_pkg::RESP_NOP;
      rd_active_reg  <= 1'b0;
      rd_pend_reg    <= 1'b0;
      rd_num_reg     <= 6'h00;
      reg_rd_addr    <= msr_pkg::AUX_BASE;
    end else begin
      cmd_exec       <= 1'b0;
      wr_data_strobe <= 1'b0;
      if (frame_start) begin
        cmd_reg   <= msr_pkg::CMD_NOP;
        resp_pend <= msr_pkg::RESP_ERR;
      end else if (frame_end) begin
        resp_reg      <= resp_pend;
        rd_active_reg <= rd_pend_reg;
        rd_pend_reg   <= 1'b0;
      end else if (word_end) begin
        if (word_idx_reg == msr_pkg::IDX_CMD) begin
          cmd_reg <= rx_half;
        end else if (word_idx_reg == msr_pkg::IDX_CRC) begin
          if (cmd_reg == msr_pkg::CMD_NOP) begin
            resp_pend <= msr_pkg::RESP_NOP;
          end else if (rd_active_reg) begin
            resp_pend <= msr_pkg::RESP_ERR;
          end else if (is_rd) begin
            cmd_exec    <= 1'b1;
            cmd_word    <= cmd_reg;
            resp_pend   <= msr_pkg::RESP_RD;
            rd_pend_reg <= 1'b1;
            reg_rd_addr <= cmd_reg.addr;
            rd_num_reg  <= {1'b0, cmd_reg.num} + 6'h01;
          end else if ((cmd_reg == msr_pkg::CMD_LOCK) || (cmd_reg == msr_pkg::CMD_UNLOCK)) begin
            cmd_exec  <= 1'b1;
            cmd_word  <= cmd_reg;
            resp_pend <= (cmd_reg == msr_pkg::CMD_LOCK) ? msr_pkg::RESP_LOCK : msr_pkg::RESP_UNLOCK;
          end
        end else if (is_wr && !rd_active_reg && (word_idx_reg < wr_last)) begin
          wr_data_strobe <= 1'b1;
          wr_data        <= rx_half;
        end
        // write needs its data CRC word
        if (is_wr && !rd_active_reg && (word_idx_reg == wr_last)) begin
          cmd_exec  <= 1'b1;
          cmd_word  <= cmd_reg;
          resp_pend <= msr_pkg::RESP_WR;
        end
        if (is_rst && !rd_active_reg && (word_idx_reg == sdo_words - 6'h01)) begin
          cmd_exec  <= 1'b1;
          cmd_word  <= cmd_reg;
          resp_pend <= msr_pkg::RESP_RST;
        end
        if (rd_active_reg && (word_idx_reg + 6'h01 <= rd_num_reg)) begin
          reg_rd_addr <= reg_rd_addr + 8'h01;
        end
      end
    end
  end

  assign to_expire = select_timeout_en && (to_cnt_reg == 24'(TIMEOUT_CYC - 1));

  // Clock pulse count and select timeout supervision
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pcnt_reg               <= 12'h000;
      exp_reg                <= 12'h000;
      to_cnt_reg             <= 24'h000000;
      to_seen_reg            <= 1'b0;
      clock_count_fault_flag <= 1'b0;
      select_timeout_flag    <= 1'b0;
    end else if (frame_start) begin
      pcnt_reg    <= 12'h000;
      exp_reg     <= {6'h00, msr_pkg::NORM_WORDS} * {6'h00, wlen};
      to_cnt_reg  <= 24'h000000;
      to_seen_reg <= 1'b0;
    end else if (frame_end) begin
      clock_count_fault_flag <= clock_counter_en && (pcnt_reg != exp_reg);
      select_timeout_flag    <= to_seen_reg;
    end else if (state_reg != msr_pkg::ST_IDLE) begin
      if (sclk_q && !sclk_s) begin
        pcnt_reg <= pcnt_reg + 12'h001;
      end
      // expected count at command CRC end
      if (word_end && (word_idx_reg == msr_pkg::IDX_CRC)) begin
        exp_reg <= {6'h00, frame_words} * {6'h00, wlen};
      end
      if (to_expire && (state_reg == msr_pkg::ST_FRAME)) begin
        to_seen_reg <= 1'b1;
      end else if (to_cnt_reg != 24'hFFFFFF) begin
        to_cnt_reg <= to_cnt_reg + 24'h000001;
      end
    end
  end

  // Latest conversion results and the per-frame copies
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      res_a_reg <= '0;
      res_b_reg <= '0;
      frm_a_reg <= '0;
      frm_b_reg <= '0;
    end else begin
      if (adc_first_done) begin
        res_a_reg <= {adc_first_value, res_a_reg.count + 2'h1};
      end
      if (adc_second_done) begin
        res_b_reg <= {adc_second_value, res_b_reg.count + 2'h1};
      end
      if (frame_start) begin
        frm_a_reg <= res_a_reg;
        frm_b_reg <= res_b_reg;
      end
    end
  end

  assign sel_done    = data_ready_source_select ? adc_second_done : adc_first_done;
  assign second_read = word_end && (word_idx_reg == msr_pkg::IDX_SECOND) && !rd_active_reg;

  // Data-ready pin
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      data_ready_pin <= 1'b1;
      new_flag_reg   <= 1'b0;
      hold_reg       <= 8'h00;
    end else begin
      // new data during frame blocks release
      if (sel_done) begin
        new_flag_reg <= 1'b1;
      end else if (frame_start) begin
        new_flag_reg <= 1'b0;
      end
      // fall, with high pulse if already low
      if (sel_done) begin
        if (!data_ready_pin) begin
          data_ready_pin <= 1'b1;
          hold_reg       <= 8'(msr_pkg::DRH_CYC);
        end else begin
          data_ready_pin <= 1'b0;
          hold_reg       <= 8'h00;
        end
      end else if (hold_reg != 8'h00) begin
        hold_reg <= hold_reg - 8'h01;
        if (hold_reg == 8'h01) begin
          data_ready_pin <= 1'b0;
        end
      end else if (conversion_start_bit) begin
        data_ready_pin <= 1'b1;
      end else if (second_read && !new_flag_reg) begin
        data_ready_pin <= 1'b1;
      end
    end
  end

endmodule // msr_spi_target

// file: core/msr_sync3.sv
// Two-flop synchroniser for the three SPI pins
`timescale 1ns/1ns
module msr_sync3 (
  input  logic       mclk,
  input  logic       rstn,
  input  logic [2:0] async_in,
  output logic [2:0] sync_out
);

  logic [2:0] meta_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 3'h7;
      sync_out <= 3'h7;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // msr_sync3

// file: testbench/msr_host.sv
// Host SPI controller model: drives select, clock and data in, captures data out
`timescale 1ns/1ns
module msr_host (
  input  wire logic mclk,
  output logic      chip_select_low,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  logic [23:0] rx [0:39];
  initial begin
    chip_select_low = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Data line toggles on every clock between frames, so it shows no stable value
  always @(posedge mclk) begin
    if (chip_select_low) begin
      sdi <= ~sdi;
    end
  end
  // command MSB first in every word, SDI changed on clock rise
  task automatic frame(input logic [15:0] cmd, input int nclk, input int hold);
    @(posedge mclk);
    chip_select_low <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < nclk; i++) begin
      sclk <= 1'b1;
      sdi <= (i % 24 < 16) ? cmd[15 - i % 24] : 1'b0;
      repeat (4) @(posedge mclk);
      sclk <= 1'b0;
      repeat (2) @(posedge mclk);
      rx[i / 24][23 - i % 24] = sdo;
      repeat (2) @(posedge mclk);
    end
    repeat (hold) @(posedge mclk);
    chip_select_low <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
endmodule // msr_host

// file: testbench/msr_properties.sv
// Port-level assertions for the monitor SPI target
`timescale 1ns/1ns
module msr_properties (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic chip_select_low,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic clock_counter_en,
  input wire logic select_timeout_en,
  input wire logic data_ready_source_select,
  input wire logic adc_first_done,
  input wire logic adc_second_done,
  input wire logic conversion_start_bit,
  input wire logic cmd_exec,
  input wire logic data_ready_pin,
  input wire logic clock_count_fault_flag,
  input wire logic select_timeout_flag
);
  localparam int DRH_W = msr_pkg::DRH_CYC + 1;
  wire sel_done = data_ready_source_select ? adc_second_done : adc_first_done;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  ready_fall_a: assert property (
    sel_done && data_ready_pin && !conversion_start_bit |=> !data_ready_pin)
    else $error("ready pin did not fall after conversion done");
  ready_pulse_a: assert property (
    sel_done && !data_ready_pin && !conversion_start_bit |=> data_ready_pin ##[1:DRH_W] !data_ready_pin)
    else $error("ready pin missed its high pulse before falling");
  start_high_a: assert property (
    conversion_start_bit && !sel_done |=> data_ready_pin)
    else $error("ready pin not high after start bit");
  ready_rise_a: assert property (
    $rose(data_ready_pin) |-> !chip_select_low || $past(conversion_start_bit) || $past(sel_done))
    else $error("ready pin rose outside a readout");
  exec_once_a: assert property (
    cmd_exec |=> !cmd_exec)
    else $error("command execute longer than one cycle");
  sdo_edge_a: assert property (
    $changed(sdo) |-> sclk)
    else $error("sdo changed while clock low");
  count_update_a: assert property (
    $changed(clock_count_fault_flag) |-> chip_select_low)
    else $error("count fault flag changed inside a frame");
  count_enable_a: assert property (
    $rose(clock_count_fault_flag) |-> clock_counter_en)
    else $error("count fault flag set while counter disabled");
  timeout_update_a: assert property (
    $changed(select_timeout_flag) |-> chip_select_low)
    else $error("timeout flag changed inside a frame");
  timeout_enable_a: assert property (
    $rose(select_timeout_flag) |-> select_timeout_en)
    else $error("timeout flag set while timeout disabled");
endmodule // msr_properties

bind msr_spi_target msr_properties u_props (
  .mclk(mclk), .rstn(rstn), .chip_select_low(chip_select_low), .sclk(sclk), .sdo(sdo),
  .clock_counter_en(clock_counter_en), .select_timeout_en(select_timeout_en),
  .data_ready_source_select(data_ready_source_select), .adc_first_done(adc_first_done),
  .adc_second_done(adc_second_done), .conversion_start_bit(conversion_start_bit), .cmd_exec(cmd_exec),
  .data_ready_pin(data_ready_pin), .clock_count_fault_flag(clock_count_fault_flag),
  .select_timeout_flag(select_timeout_flag)
);

// file: testbench/tb_top.sv
// Self-checking bench for the monitor SPI target
`timescale 1ns/1ns
module tb_top;
  logic        mclk, rstn, chip_select_low, sclk, sdi, sdo, word_length_sel;
  logic        clock_counter_en, select_timeout_en, data_ready_source_select, conversion_start_bit;
  logic        adc_first_done, adc_second_done, reg_rd_valid, cmd_exec, wr_data_strobe;
  logic        data_ready_pin, clock_count_fault_flag, select_timeout_flag;
  logic [23:0] adc_first_value, adc_second_value;
  logic [7:0]  reg_rd_addr;
  logic [15:0] reg_rd_value, cmd_word, wr_data;
  int          n_errors, checked, n_exec, n_wr;

  // Register file model: address 0Fh is not a valid register
  assign reg_rd_valid = (reg_rd_addr != 8'h0F);
  assign reg_rd_value = {8'h5A, reg_rd_addr};

  msr_spi_target #(.TIMEOUT_CYC(500)) dut (
    .mclk(mclk), .rstn(rstn), .chip_select_low(chip_select_low), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .word_length_sel(word_length_sel), .clock_counter_en(clock_counter_en),
    .select_timeout_en(select_timeout_en), .data_ready_source_select(data_ready_source_select),
    .adc_first_done(adc_first_done), .adc_first_value(adc_first_value), .adc_second_done(adc_second_done),
    .adc_second_value(adc_second_value), .reg_rd_addr(reg_rd_addr), .reg_rd_value(reg_rd_value),
    .reg_rd_valid(reg_rd_valid), .conversion_start_bit(conversion_start_bit), .cmd_exec(cmd_exec),
    .cmd_word(cmd_word), .wr_data_strobe(wr_data_strobe), .wr_data(wr_data), .data_ready_pin(data_ready_pin),
    .clock_count_fault_flag(clock_count_fault_flag), .select_timeout_flag(select_timeout_flag)
  );
  msr_host u_host (.mclk(mclk), .chip_select_low(chip_select_low), .sclk(sclk), .sdi(sdi), .sdo(sdo));

  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    if (cmd_exec && cmd_word != 16'h0000) begin
      n_exec++;
    end
    if (wr_data_strobe) begin
      n_wr++;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (exp !== got) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic conv(input logic [23:0] a, input logic [23:0] b);
    @(posedge mclk);
    adc_first_done <= 1'b1;
    adc_second_done <= 1'b1;
    adc_first_value <= a;
    adc_second_value <= b;
    @(posedge mclk);
    adc_first_done <= 1'b0;
    adc_second_done <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask
  task automatic nop(input int n);
    u_host.frame(msr_pkg::CMD_NOP, n, 0);
  endtask
  task automatic data(input logic [23:0] a, input logic [23:0] b, input logic [3:0] c);
    chk("first value", a, u_host.rx[1]);
    chk("second value", b, u_host.rx[2]);
    chk("counters", c, u_host.rx[0][17:14]);
    chk("output crc", 0, u_host.rx[3]);
  endtask

  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    word_length_sel = 1'b0;
    clock_counter_en = 1'b1;
    select_timeout_en = 1'b0;
    data_ready_source_select = 1'b0;
    adc_first_done = 1'b0;
    adc_second_done = 1'b0;
    adc_first_value = 24'h000000;
    adc_second_value = 24'h000000;
    conversion_start_bit = 1'b0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("ready idle", 1, data_ready_pin);
    chk("read addr", 8'h10, reg_rd_addr);
    conv(24'h123456, 24'hABCDEF);
    chk("ready low", 0, data_ready_pin);
    nop(96);
    chk("ready high", 1, data_ready_pin);
    chk("count fault", 0, clock_count_fault_flag);
    data(24'h123456, 24'hABCDEF, 4'h5);
    nop(96);
    data(24'h123456, 24'hABCDEF, 4'h5);
    chk("response", msr_pkg::RESP_NOP, u_host.rx[0][21:18]);
    conv(24'h0F0F0F, 24'h707070);
    nop(48);
    chk("ready kept", 0, data_ready_pin);
    chk("count fault", 1, clock_count_fault_flag);
    nop(100);
    chk("fault status", 1, u_host.rx[0][23]);
    chk("count fault", 1, clock_count_fault_flag);
    data(24'h0F0F0F, 24'h707070, 4'hA);
    data_ready_source_select <= 1'b1;
    conv(24'h111111, 24'h222222);
    chk("ready low", 0, data_ready_pin);
    conv(24'h333333, 24'h444444);
    chk("ready low", 0, data_ready_pin);
    nop(96);
    data(24'h333333, 24'h444444, 4'h0);
    u_host.frame({msr_pkg::OP_RD, 8'h0E, 5'h1F}, 96, 0);
    chk("read exec", 1, n_exec);
    nop(816);
    chk("response", msr_pkg::RESP_RD, u_host.rx[0][21:18]);
    for (int k = 0; k < 32; k++) begin
      chk("read word", (k == 1) ? 24'h0 : {8'h5A, 8'h0E + k[7:0], 8'h0E + k[7:0]}, u_host.rx[k + 1]);
    end
    chk("read crc", 0, u_host.rx[33]);
    chk("count fault", 0, clock_count_fault_flag);
    u_host.frame({msr_pkg::OP_RD, 8'h10, 5'h00}, 96, 0);
    u_host.frame(msr_pkg::CMD_LOCK, 72, 0);
    nop(96);
    chk("refused", msr_pkg::RESP_ERR, u_host.rx[0][21:18]);
    chk("exec count", 2, n_exec);
    u_host.frame(msr_pkg::CMD_RST, 72, 0);
    chk("reset early", 2, n_exec);
    u_host.frame(msr_pkg::CMD_RST, 96, 0);
    chk("reset taken", 3, n_exec);
    u_host.frame({msr_pkg::OP_WR, 8'h45, 5'h01}, 96, 0);
    chk("write short", 3, n_exec);
    chk("write strobes", 2, n_wr);
    chk("count fault", 1, clock_count_fault_flag);
    u_host.frame({msr_pkg::OP_WR, 8'h45, 5'h01}, 120, 0);
    chk("refused", msr_pkg::RESP_ERR, u_host.rx[0][21:18]);
    chk("write taken", 4, n_exec);
    chk("write strobes", 4, n_wr);
    chk("write data", 16'h68A1, wr_data);
    chk("write word", 16'h68A1, cmd_word);
    chk("count fault", 0, clock_count_fault_flag);
    conv(24'h555555, 24'h666666);
    conversion_start_bit <= 1'b1;
    @(posedge mclk);
    conversion_start_bit <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("ready start", 1, data_ready_pin);
    select_timeout_en <= 1'b1;
    conv(24'h777777, 24'h888888);
    nop(96);
    chk("timeout flag", 1, select_timeout_flag);
    chk("ready kept", 0, data_ready_pin);
    chk("response", msr_pkg::RESP_WR, u_host.rx[0][21:18]);
    select_timeout_en <= 1'b0;
    nop(96);
    chk("timeout flag", 0, select_timeout_flag);
    data(24'h777777, 24'h888888, 4'hA);
    // conversion completes while the results are read
    fork
      nop(96);
      begin
        repeat (200) @(posedge mclk);
        conv(24'h99AA00, 24'hBBCC00);
      end
    join
    chk("ready kept", 0, data_ready_pin);
    data(24'h777777, 24'h888888, 4'hA);
    nop(96);
    data(24'h99AA00, 24'hBBCC00, 4'hF);
    chk("ready high", 1, data_ready_pin);
    tally_and_finish();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end
endmodule // tb_top
